/* sdc_decoder.sv */
// Command decoder and bank control front end of a four-bank SDRAM.
`timescale 1ns/10ps
// Overview of operation
// - All inputs but the asynchronous reset sampled on rising clock edge.
// - Access is activate, then read or write.
// - Bursts generate column addresses internally.
// - New column address accepted every cycle.
// - Precharge one bank while another works.
// - Auto precharge closes row after burst.
// - Chip select high executes nothing.
// - No-operation leaves operations untouched.
// - Activate picks bank and row.
// - Read and write decode, bank and column.
// - A10 auto precharge per command only.
// - Burst stop or deep power-down by enable.
// - Burst stop legal with or without data.
// - Precharge one bank or all banks.
// - Auto or self refresh by clock enable.
// - Refresh row from internal counter.
// - Mode register load takes A[11:0].
// - Mask: writes immediate, reads two clocks later.
// - Burst stop truncates latest read or write.
module sdc_decoder #(
    parameter int ROW_W     = sdc_pkg::ADDR_W,
    parameter int ACC_DEPTH = 4
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    // Command bus from the controller
    input  wire sdc_pkg::sdc_pins_t          pins_i,
    // Column access stream to the array
    output logic                             acc_valid_o,
    input  wire logic                        acc_ready_i,
    output sdc_pkg::sdc_access_t             acc_o,
    output logic                             acc_stall_o,
    // Read data output gating
    output logic                             rd_out_en_o,
    // Status
    output sdc_pkg::sdc_cmd_t                cmd_o,
    output logic [sdc_pkg::NUM_BANKS*2-1:0]  bank_state_o,
    output logic [ROW_W-1:0]                 refresh_row_o,
    output logic [sdc_pkg::MODE_W-1:0]       mode_o,
    output logic                             self_refresh_o,
    output logic                             deep_power_down_o,
    output logic                             illegal_cmd_o
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Chip select high overrides every other pin, so a deselected device starts nothing.
    function automatic sdc_pkg::sdc_cmd_t decode(input sdc_pkg::sdc_pins_t p);
        sdc_pkg::sdc_cmd_t c;
        c = sdc_pkg::CMD_INHIBIT;
        if (!p.cs_n) begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h7: c = sdc_pkg::CMD_NO_OPERATION;
                3'h3: c = sdc_pkg::CMD_ACTIVATE;
                3'h5: c = sdc_pkg::CMD_READ;
                3'h4: c = sdc_pkg::CMD_WRITE;
                3'h6: c = p.cke ? sdc_pkg::CMD_BURST_STOP
                                : sdc_pkg::CMD_DEEP_POWER_DOWN;
                3'h2: c = sdc_pkg::CMD_PRECHARGE;
                3'h1: c = p.cke ? sdc_pkg::CMD_AUTO_REFRESH
                                : sdc_pkg::CMD_SELF_REFRESH;
                3'h0: c = sdc_pkg::CMD_MODE_REGISTER_LOAD;
                default: c = sdc_pkg::CMD_NO_OPERATION;
            endcase
        end
        return c;
    endfunction

    // The full-page code maps to shift zero; such bursts end only on a stop, a precharge or a new read or write.
    function automatic logic [2:0] burst_len(input logic [2:0] code);
        return code == sdc_pkg::BL_FULL_PAGE ? 3'h0 : code;
    endfunction

    sdc_pkg::sdc_pins_t   pins_r;
    sdc_pkg::sdc_cmd_t    cmd;
    logic [1:0]           bank;
    logic                 ap;

    // Everything is captured on the rising edge before decoding.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                        cke: 1'b1, dqm: 1'b1, default: '0};
        end else begin
            pins_r <= pins_i;
        end
    end

    assign cmd  = decode(pins_r);
    assign bank = {pins_r.bank_select_bit1, pins_r.bank_select_bit0};
    assign ap   = pins_r.addr[sdc_pkg::AP_BIT];

    // ------------------------------------------------------------------
    // Bank, burst and mode state
    // ------------------------------------------------------------------
    sdc_pkg::sdc_bank_t      bst_r [sdc_pkg::NUM_BANKS];
    sdc_pkg::sdc_bank_t      bst_nxt [sdc_pkg::NUM_BANKS];
    logic [ROW_W-1:0]        row_r [sdc_pkg::NUM_BANKS];
    logic [ROW_W-1:0]        row_nxt [sdc_pkg::NUM_BANKS];
    logic [sdc_pkg::MODE_W-1:0] mode_r, mode_nxt;
    logic [ROW_W-1:0]        rfc_r, rfc_nxt;
    logic [sdc_pkg::COL_W-1:0] col_r, col_nxt, base_r, base_nxt;
    logic [sdc_pkg::COL_W-1:0] step_r, step_nxt;
    logic [1:0]              bbank_r, bbank_nxt;
    logic                    bact_r, bact_nxt, bwr_r, bwr_nxt, bap_r, bap_nxt;
    logic                    sr_r, sr_nxt, dpd_r, dpd_nxt, ill_r, ill_nxt;
    logic [sdc_pkg::RD_MASK_LAT-1:0] dqm_pipe_r, dqm_pipe_nxt;
    logic                    issue, fifo_ready, last;
    logic [sdc_pkg::COL_W-1:0] blen, nstep;
    sdc_pkg::sdc_access_t    acc;

    // Lengths are powers of two of the mode code; reserved codes give longer bursts
    // rather than a fault, which keeps the decode small.
    assign blen  = sdc_pkg::COL_W'(1) << burst_len(mode_r[sdc_pkg::BL_MSB:sdc_pkg::BL_LSB]);
    assign nstep = step_r + 1'b1;
    assign last  = (mode_r[sdc_pkg::BL_MSB:sdc_pkg::BL_LSB] != sdc_pkg::BL_FULL_PAGE)
                   && (nstep == blen);

    always_comb begin
        for (int b = 0; b < sdc_pkg::NUM_BANKS; b++) begin
            bst_nxt[b] = bst_r[b];
            row_nxt[b] = row_r[b];
        end
        mode_nxt = mode_r;
        rfc_nxt = rfc_r;
        col_nxt = col_r;
        base_nxt = base_r;
        step_nxt = step_r;
        bbank_nxt = bbank_r;
        bact_nxt = bact_r;
        bwr_nxt = bwr_r;
        bap_nxt = bap_r;
        sr_nxt = sr_r && !pins_r.cke;
        dpd_nxt = dpd_r && !pins_r.cke;
        ill_nxt = 1'b0;
        issue = 1'b0;
        acc = '{write: bwr_r, mask: pins_r.dqm, bank: bbank_r, col: col_r};
        // Burst advance; interleaved order flips the low bits of the start.
        if (bact_r && fifo_ready) begin
            issue = 1'b1;
            step_nxt = nstep;
            col_nxt = mode_r[sdc_pkg::BT_BIT] ? (base_r ^ nstep)
                                             : (base_r + nstep);
            if (last) begin
                bact_nxt = 1'b0;
                bst_nxt[bbank_r] = bap_r ? sdc_pkg::BANK_IDLE
                                         : sdc_pkg::BANK_ACTIVE;
            end
        end
        if (!sr_r && !dpd_r) begin
            case (cmd)
                sdc_pkg::CMD_ACTIVATE: begin
                    if (bst_r[bank] == sdc_pkg::BANK_IDLE) begin
                        bst_nxt[bank] = sdc_pkg::BANK_ACTIVE;
                        row_nxt[bank] = pins_r.addr[ROW_W-1:0];
                    end else begin
                        ill_nxt = 1'b1;
                    end
                end
                sdc_pkg::CMD_READ, sdc_pkg::CMD_WRITE: begin
                    if (bst_r[bank] != sdc_pkg::BANK_IDLE) begin
                        // A new column command replaces the running burst; the old bank, if another, settles
                        // as its own auto precharge choice asks, but keeps its read or write state if its last access waits on a full FIFO.
                        if (bact_r && !last && bbank_r != bank) begin
                            bst_nxt[bbank_r] = bap_r ? sdc_pkg::BANK_IDLE
                                                     : sdc_pkg::BANK_ACTIVE;
                        end
                        bst_nxt[bank] = (cmd == sdc_pkg::CMD_WRITE)
                                        ? sdc_pkg::BANK_WRITE
                                        : sdc_pkg::BANK_READ;
                        bbank_nxt = bank;
                        base_nxt = pins_r.addr[sdc_pkg::COL_W-1:0];
                        col_nxt = pins_r.addr[sdc_pkg::COL_W-1:0];
                        step_nxt = '0;
                        bwr_nxt = (cmd == sdc_pkg::CMD_WRITE);
                        bap_nxt = ap;
                        bact_nxt = 1'b1;
                    end else begin
                        ill_nxt = 1'b1;
                    end
                end
                sdc_pkg::CMD_BURST_STOP: begin
                    if (bact_r) begin
                        bact_nxt = 1'b0;
                        bst_nxt[bbank_r] = bap_r ? sdc_pkg::BANK_IDLE
                                                 : sdc_pkg::BANK_ACTIVE;
                    end
                end
                sdc_pkg::CMD_PRECHARGE: begin
                    for (int b = 0; b < sdc_pkg::NUM_BANKS; b++) begin
                        if (ap || bank == b[1:0]) begin
                            bst_nxt[b] = sdc_pkg::BANK_IDLE;
                            // Closing the bursting bank also ends its burst.
                            if (bact_r && bbank_r == b[1:0]) begin
                                bact_nxt = 1'b0;
                            end
                        end
                    end
                end
                sdc_pkg::CMD_AUTO_REFRESH, sdc_pkg::CMD_SELF_REFRESH: begin
                    // The row counter wraps freely; it only has to visit every row.
                    rfc_nxt = rfc_r + 1'b1;
                    sr_nxt = (cmd == sdc_pkg::CMD_SELF_REFRESH);
                end
                sdc_pkg::CMD_DEEP_POWER_DOWN: begin
                    // Open banks are not checked here; keeping them idle is the controller's.
                    dpd_nxt = 1'b1;
                end
                sdc_pkg::CMD_MODE_REGISTER_LOAD: begin
                    mode_nxt = pins_r.addr[sdc_pkg::MODE_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Read mask takes effect two clocks after it was sampled.
        dqm_pipe_nxt = {dqm_pipe_r[sdc_pkg::RD_MASK_LAT-2:0], pins_r.dqm};
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int b = 0; b < sdc_pkg::NUM_BANKS; b++) begin
                bst_r[b] <= sdc_pkg::BANK_IDLE;
                row_r[b] <= '0;
            end
            mode_r <= sdc_pkg::MODE_RST;
            rfc_r <= '0;
            col_r <= '0;
            base_r <= '0;
            step_r <= '0;
            bbank_r <= '0;
            bact_r <= 1'b0;
            bwr_r <= 1'b0;
            bap_r <= 1'b0;
            sr_r <= 1'b0;
            dpd_r <= 1'b0;
            ill_r <= 1'b0;
            dqm_pipe_r <= '1;
            cmd_o <= sdc_pkg::CMD_INHIBIT;
        end else begin
            bst_r <= bst_nxt;
            row_r <= row_nxt;
            mode_r <= mode_nxt;
            rfc_r <= rfc_nxt;
            col_r <= col_nxt;
            base_r <= base_nxt;
            step_r <= step_nxt;
            bbank_r <= bbank_nxt;
            bact_r <= bact_nxt;
            bwr_r <= bwr_nxt;
            bap_r <= bap_nxt;
            sr_r <= sr_nxt;
            dpd_r <= dpd_nxt;
            ill_r <= ill_nxt;
            dqm_pipe_r <= dqm_pipe_nxt;
            cmd_o <= cmd;
        end
    end

    // ------------------------------------------------------------------
    // Access path; a full FIFO holds the burst counter still.
    // ------------------------------------------------------------------
    // A shallow queue absorbs short array pauses; a longer pause stalls the burst.
    sdc_fifo #(
        .WIDTH ($bits(sdc_pkg::sdc_access_t)),
        .DEPTH (ACC_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (issue),
        .in_ready_o  (fifo_ready),
        .in_data_i   (acc),
        .out_valid_o (acc_valid_o),
        .out_ready_i (acc_ready_i),
        .out_data_o  (acc_o)
    );

    // Two bits per bank, bank 0 in the lowest pair.
    genvar g;
    generate
        for (g = 0; g < sdc_pkg::NUM_BANKS; g++) begin : g_bst
            assign bank_state_o[2*g+1:2*g] = bst_r[g];
        end
    endgenerate

    // Stall is combinational so the controller sees back-pressure in the same cycle.
    assign acc_stall_o       = bact_r && !fifo_ready;
    assign rd_out_en_o       = !dqm_pipe_r[sdc_pkg::RD_MASK_LAT-1];
    assign refresh_row_o     = rfc_r;
    assign mode_o            = mode_r;
    assign self_refresh_o    = sr_r;
    assign deep_power_down_o = dpd_r;
    assign illegal_cmd_o     = ill_r;
endmodule

/* sdc_pkg.sv */
// Package with shared constants and types of the SDRAM command decoder.
package sdc_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int ADDR_W      = 13;
    localparam int COL_W       = 10;
    localparam int MODE_W      = 12;
    localparam int NUM_BANKS   = 4;
    localparam int RD_MASK_LAT = 2;
    localparam int AP_BIT      = 10;

    // ------------------------------------------------------------------
    // Mode register fields and reset value
    // ------------------------------------------------------------------
    localparam int BL_LSB   = 0;
    localparam int BL_MSB   = 2;
    localparam int BT_BIT   = 3;
    localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
    localparam logic [2:0] BL_FULL_PAGE    = 3'h7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_INHIBIT,
        CMD_NO_OPERATION,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_BURST_STOP,
        CMD_DEEP_POWER_DOWN,
        CMD_PRECHARGE,
        CMD_AUTO_REFRESH,
        CMD_SELF_REFRESH,
        CMD_MODE_REGISTER_LOAD
    } sdc_cmd_t;

    typedef enum logic [1:0] {
        BANK_IDLE,
        BANK_ACTIVE,
        BANK_READ,
        BANK_WRITE
    } sdc_bank_t;

    // Sampled command bus pins; the four command strobes are active low, clock enable and mask active high.
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              cke;
        logic              dqm;
        logic              bank_select_bit1;
        logic              bank_select_bit0;
        logic [ADDR_W-1:0] addr;
    } sdc_pins_t;

    // One column access handed to the array.
    typedef struct packed {
        logic             write;
        logic             mask;
        logic [1:0]       bank;
        logic [COL_W-1:0] col;
    } sdc_access_t;

endpackage

/* sdc_fifo.sv */
// Small valid/ready FIFO used on the column access path.
`timescale 1ns/10ps
module sdc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    assign in_ready_o  = (cnt_r < (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rp_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        wp_nxt  = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt  = pop  ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
endmodule

/* sdc_ctrl_model.sv */
// Behavioural memory controller that drives the decoder's command bus.
`timescale 1ns/10ps
module sdc_ctrl_model (
    // Clock
    input  wire logic          clk_i,
    // Command bus
    output sdc_pkg::sdc_pins_t pins_o
);
    initial begin
        pins_o      = '0;
        pins_o.cs_n = 1'b1;
        pins_o.cke  = 1'b1;
    end

    // Fields move just after a falling edge so they are settled at the rising edge.
    task automatic send(input logic [3:0] op, input logic cke, input logic dqm,
                        input logic [1:0] bank, input logic [12:0] addr);
        @(negedge clk_i);
        {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= op;
        pins_o.cke <= cke;
        pins_o.dqm <= dqm;
        {pins_o.bank_select_bit1, pins_o.bank_select_bit0} <= bank;
        pins_o.addr <= addr;
    endtask

    // Address and bank lines mean nothing on idle cycles, so the address and bank_select_bit0
    // flip every cycle; any logic that wrongly uses them then shows up at once.
    task automatic no_operation(input logic cke, input logic dqm);
        @(negedge clk_i);
        {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= 4'h7;
        pins_o.cke <= cke;
        pins_o.dqm <= dqm;
        pins_o.bank_select_bit0 <= ~pins_o.bank_select_bit0;
        pins_o.addr <= ~pins_o.addr;
    endtask
endmodule

/* sdc_decoder_properties.sv */
// Concurrent checks on the ports of the SDRAM command decoder.
`timescale 1ns/10ps
module sdc_decoder_chk #(
    parameter int ROW_W = sdc_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic                              clk_i,
    input wire logic                              rst_n_i,
    // Command bus and access stream
    input wire sdc_pkg::sdc_pins_t                pins_i,
    input wire logic                              acc_valid_o,
    input wire logic                              acc_ready_i,
    input wire sdc_pkg::sdc_access_t              acc_o,
    input wire logic                              acc_stall_o,
    input wire logic                              rd_out_en_o,
    // Status
    input wire sdc_pkg::sdc_cmd_t                 cmd_o,
    input wire logic [sdc_pkg::NUM_BANKS*2-1:0]   bank_state_o,
    input wire logic [ROW_W-1:0]                  refresh_row_o,
    input wire logic [sdc_pkg::MODE_W-1:0]        mode_o,
    input wire logic                              self_refresh_o,
    input wire logic                              deep_power_down_o,
    input wire logic                              illegal_cmd_o
);
    logic [3:0] op;
    logic [1:0] bsel;
    logic       live;
    assign op   = {pins_i.cs_n, pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
    assign bsel = {pins_i.bank_select_bit1, pins_i.bank_select_bit0};
    // Power-saving states swallow commands, so decode checks skip them.
    assign live = !self_refresh_o && !deep_power_down_o;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_inhibit_decode: assert property (
        $past(pins_i.cs_n, 2) && $past(live) |-> cmd_o == sdc_pkg::CMD_INHIBIT)
        else $error("deselected cycle decoded as a command");
    a_inhibit_hold: assert property (
        pins_i.cs_n |=> ##1 $stable(mode_o))
        else $error("mode register changed while deselected");
    a_noop_decode: assert property (
        $past(op, 2) == 4'h7 && $past(live) |-> cmd_o == sdc_pkg::CMD_NO_OPERATION)
        else $error("no-operation decoded wrongly");
    a_refresh_decode: assert property (
        $past(op, 2) == 4'h1 && $past(pins_i.cke, 2) && $past(live)
        |-> cmd_o == sdc_pkg::CMD_AUTO_REFRESH)
        else $error("auto refresh not decoded");
    a_self_refresh_entry: assert property (
        $past(op, 2) == 4'h1 && !$past(pins_i.cke, 2) && $past(live) |-> self_refresh_o)
        else $error("self refresh not entered");
    a_power_down_entry: assert property (
        $past(op, 2) == 4'h6 && !$past(pins_i.cke, 2) && $past(live)
        && $past(bank_state_o) == '0 |-> deep_power_down_o)
        else $error("deep power-down not entered");
    a_mode_load: assert property (
        $past(op, 2) == 4'h0 && $past(pins_i.cke, 2) && $past(live)
        && $past(bank_state_o) == '0 |-> mode_o == $past(pins_i.addr[11:0], 2))
        else $error("mode register not loaded from address");
    a_precharge_all: assert property (
        $past(op, 2) == 4'h2 && $past(pins_i.addr[sdc_pkg::AP_BIT], 2) && $past(live)
        |-> bank_state_o == '0)
        else $error("precharge all left a bank open");
    a_read_idle_bank: assert property (
        $past(op) == 4'h5 && $past(pins_i.cke) && live
        && bank_state_o[2*$past(bsel) +: 2] == 2'h0 |=> illegal_cmd_o)
        else $error("read to idle bank not flagged");
    a_mask_read: assert property (
        $past(pins_i.dqm, 3) |-> !rd_out_en_o)
        else $error("read output enabled despite mask");
endmodule

bind sdc_decoder sdc_decoder_chk #(.ROW_W(ROW_W)) chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins_i), .acc_valid_o(acc_valid_o),
    .acc_ready_i(acc_ready_i), .acc_o(acc_o), .acc_stall_o(acc_stall_o),
    .rd_out_en_o(rd_out_en_o), .cmd_o(cmd_o), .bank_state_o(bank_state_o),
    .refresh_row_o(refresh_row_o), .mode_o(mode_o), .self_refresh_o(self_refresh_o),
    .deep_power_down_o(deep_power_down_o), .illegal_cmd_o(illegal_cmd_o));

/* tb_top.sv */
// Self-checking testbench of the SDRAM command decoder.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s: expected %0h, seen %0h", nm, exp, got); end end
module tb_top;
    localparam logic [3:0] OP_INH = 4'h8, OP_ACT = 4'h3, OP_RD = 4'h5, OP_WR = 4'h4;
    localparam logic [3:0] OP_STOP = 4'h6, OP_PRE = 4'h2, OP_REF = 4'h1, OP_MODE = 4'h0;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic acc_ready_i = 1'b1;
    sdc_pkg::sdc_pins_t pins;
    sdc_pkg::sdc_access_t acc_o;
    sdc_pkg::sdc_cmd_t cmd_o;
    logic acc_valid_o, acc_stall_o, rd_out_en_o, self_refresh_o, deep_power_down_o;
    logic illegal_cmd_o;
    logic [7:0] bank_state_o;
    logic [12:0] refresh_row_o, r0;
    logic [11:0] mode_o;
    int miscompares = 0;
    int cmp_count = 0;
    sdc_pkg::sdc_access_t seen_q[$];

    always #2.5 clk_i = ~clk_i;

    sdc_ctrl_model ctl_u (.clk_i(clk_i), .pins_o(pins));
    sdc_decoder dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins),
        .acc_valid_o(acc_valid_o), .acc_ready_i(acc_ready_i), .acc_o(acc_o),
        .acc_stall_o(acc_stall_o), .rd_out_en_o(rd_out_en_o), .cmd_o(cmd_o),
        .bank_state_o(bank_state_o), .refresh_row_o(refresh_row_o), .mode_o(mode_o),
        .self_refresh_o(self_refresh_o), .deep_power_down_o(deep_power_down_o),
        .illegal_cmd_o(illegal_cmd_o));

    always @(posedge clk_i) if (acc_valid_o === 1'b1 && acc_ready_i === 1'b1) seen_q.push_back(acc_o);

    task automatic idle(input int n, input logic cke = 1'b1, input logic dqm = 1'b0);
        repeat (n) ctl_u.no_operation(cke, dqm);
    endtask

    // Returns at the falling edge where the command's results are visible.
    task automatic cmd(input logic [3:0] op, input logic [1:0] b, input logic [12:0] a,
                       input logic cke = 1'b1, input logic dqm = 1'b0);
        ctl_u.send(op, cke, dqm, b, a);
        idle(2, cke, dqm);
    endtask

    task automatic chk_q(input int n, input logic [1:0] b, input logic wr, input logic mk,
                         input logic [9:0] st, input logic ilv);
        sdc_pkg::sdc_access_t e;
        `CHK("access count", n, seen_q.size())
        for (int i = 0; i < n && i < seen_q.size(); i++) begin
            e = '{write: wr, mask: mk, bank: b, col: ilv ? st ^ i[9:0] : st + i[9:0]};
            `CHK("access", e, seen_q[i])
        end
        seen_q.delete();
    endtask

    task automatic summarize();
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        `CHK("bank state", 8'h00, bank_state_o)
        `CHK("mode", sdc_pkg::MODE_RST, mode_o)
        `CHK("command", sdc_pkg::CMD_INHIBIT, cmd_o)
        `CHK("access valid", 1'b0, acc_valid_o)
        ctl_u.send(OP_INH, 1'b0, 1'b1, 2'h3, 13'h1FFF);
        idle(2);
        `CHK("command", sdc_pkg::CMD_INHIBIT, cmd_o)
        `CHK("mode", sdc_pkg::MODE_RST, mode_o)
        `CHK("self refresh", 1'b0, self_refresh_o)
        cmd(OP_MODE, 2'h0, 13'h1002);
        `CHK("mode", 12'h002, mode_o)
        `CHK("command", sdc_pkg::CMD_MODE_REGISTER_LOAD, cmd_o)
        cmd(OP_ACT, 2'h1, 13'h1ABC);
        `CHK("bank state", 8'h04, bank_state_o)
        `CHK("command", sdc_pkg::CMD_ACTIVATE, cmd_o)
        idle(1);
        `CHK("command", sdc_pkg::CMD_NO_OPERATION, cmd_o)
        `CHK("bank state", 8'h04, bank_state_o)
        seen_q.delete();
        cmd(OP_RD, 2'h1, 13'h0405);
        `CHK("command", sdc_pkg::CMD_READ, cmd_o)
        idle(8);
        chk_q(4, 2'h1, 1'b0, 1'b0, 10'h005, 1'b0);
        `CHK("read output enable", 1'b1, rd_out_en_o)
        `CHK("bank state", 8'h00, bank_state_o)
        cmd(OP_RD, 2'h1, 13'h0005);
        `CHK("illegal", 1'b1, illegal_cmd_o)
        idle(4);
        `CHK("access count", 0, seen_q.size())
        cmd(OP_MODE, 2'h0, 13'h000A);
        cmd(OP_ACT, 2'h2, 13'h0123);
        cmd(OP_WR, 2'h2, 13'h0005, 1'b1, 1'b1);
        `CHK("command", sdc_pkg::CMD_WRITE, cmd_o)
        idle(8, 1'b1, 1'b1);
        chk_q(4, 2'h2, 1'b1, 1'b1, 10'h005, 1'b1);
        `CHK("bank2 open", 1'b1, bank_state_o[5:4] != 2'h0)
        `CHK("read output enable", 1'b0, rd_out_en_o)
        idle(3);
        `CHK("read output enable", 1'b0, rd_out_en_o)
        idle(1);
        `CHK("read output enable", 1'b1, rd_out_en_o)
        cmd(OP_PRE, 2'h2, 13'h0000);
        `CHK("bank state", 8'h00, bank_state_o)
        `CHK("command", sdc_pkg::CMD_PRECHARGE, cmd_o)
        cmd(OP_MODE, 2'h0, 13'h0007);
        cmd(OP_ACT, 2'h1, 13'h0011);
        cmd(OP_ACT, 2'h2, 13'h0022);
        acc_ready_i = 1'b0;
        ctl_u.send(OP_WR, 1'b1, 1'b0, 2'h1, 13'h0000);
        for (int i = 0; i < 20 && acc_stall_o !== 1'b1; i++) idle(1);
        if (acc_stall_o !== 1'b1) begin
            miscompares++;
            summarize();
        end
        `CHK("access valid", 1'b1, acc_valid_o)
        cmd(OP_PRE, 2'h2, 13'h0000);
        `CHK("bank state", 8'h0C, bank_state_o)
        cmd(OP_STOP, 2'h0, 13'h1FFF);
        `CHK("command", sdc_pkg::CMD_BURST_STOP, cmd_o)
        acc_ready_i = 1'b1;
        idle(8);
        chk_q(4, 2'h1, 1'b1, 1'b0, 10'h000, 1'b0);
        `CHK("access valid", 1'b0, acc_valid_o)
        cmd(OP_STOP, 2'h0, 13'h0000);
        `CHK("command", sdc_pkg::CMD_BURST_STOP, cmd_o)
        cmd(OP_PRE, 2'h3, 13'h0400);
        `CHK("bank state", 8'h00, bank_state_o)
        r0 = refresh_row_o;
        cmd(OP_REF, 2'h3, 13'h1555);
        `CHK("command", sdc_pkg::CMD_AUTO_REFRESH, cmd_o)
        `CHK("refresh row moved", 1'b1, refresh_row_o !== r0)
        cmd(OP_REF, 2'h0, 13'h0000, 1'b0);
        `CHK("self refresh", 1'b1, self_refresh_o)
        cmd(OP_MODE, 2'h0, 13'h0123, 1'b0);
        `CHK("mode", 12'h007, mode_o)
        idle(3);
        `CHK("self refresh", 1'b0, self_refresh_o)
        cmd(OP_STOP, 2'h0, 13'h0000, 1'b0);
        `CHK("deep power-down", 1'b1, deep_power_down_o)
        idle(3);
        `CHK("deep power-down", 1'b0, deep_power_down_o)
        summarize();
    end
endmodule
